// ### design/atp_core.v
/*
 * converter test register, port input view, result registers and mode
 * handling for an on-chip successive-approximation converter.
 * assumes a byte register port with read data one cycle after the strobe,
 * pins already synchronous to clk_sys, and a comparator answer from the
 * analog side on cmp_hi.
 */
// Design decision made here: the strobed register port.
// Notes on behaviour
// - normal mode: test bytes read zero, ignore writes
// - special mode: test bytes read live approximation
// - special mode: test write loads approximation bits, except in stop mode
// - soft reset restores power-on state, sets power-up
// - four select bits, one output route bit
// - pin input register shows eight pin levels
// - pin view follows pins, writes ignored
// - results left-justified in sixteen bits
// - results read-only in normal mode
// - results need no reset value
// - stop mode aborts running sequence
// - wait mode halts only with halt-in-wait
// - power-up clear stops converter, registers usable
// - debug mode follows control three options
// - control five write restarts, clears flags
`timescale 1ns/100ps
`include "atp_regs.vh"

module atp_core #(
    parameter RES_BITS = 10,
    parameter NUM_RES = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // chip modes
    input wire special_mode,
    input wire stop_mode,
    input wire wait_mode,
    input wire debug_mode,
    // analog side
    input wire [7:0] analog_pin_digital_in,
    input wire cmp_hi,
    output reg [2:0] sample_chan,
    output reg [RES_BITS-1:0] dac_code,
    output reg [3:0] factory_test_select,
    output reg test_mux_output
);

// ==========================================================
// registers
reg [7:0] ctl_two_r;
reg [7:0] ctl_three_r;
reg [7:0] ctl_five_r;
reg [RES_BITS-1:0] sar_r;
reg [3:0] tst_sel_r;
reg tst_out_r;
reg [7:0] pin_r;
reg [15:0] result_mem [0:NUM_RES-1];
reg seq_done_r;
reg [7:0] chan_flags_r;
reg [2:0] conv_idx_r;
reg [3:0] bit_idx_r;
reg [4:0] tick_r;
reg busy_r;
reg soft_rst_r;

wire wr_test_ok;
wire rst_any;
wire halt_now;
wire [2:0] seq_len_m1;
wire [2:0] res_slot;
wire [2:0] cur_chan;
wire [15:0] res_word;

// top bit index of the approximation, sized for the bit counter
localparam [3:0] TOP_BIT = RES_BITS - 1;

// result slot addressed by a byte offset
function [2:0] res_index;
    input [7:0] a;
    begin
        res_index = a[3:1];
    end
endfunction

// soft reset acts one cycle after the bit is written
assign rst_any = !reset_n || soft_rst_r;
// test byte writes only count in special mode
assign wr_test_ok = reg_wr && special_mode;
assign halt_now = stop_mode || !ctl_two_r[`ATP_BIT_PWR_UP]
    || (wait_mode && ctl_two_r[`ATP_BIT_HALT_WAIT])
    || (debug_mode && ctl_three_r[`ATP_BIT_FREEZE]);
assign seq_len_m1 = ctl_five_r[`ATP_BIT_S8CM] ? 3'h7 : 3'h3;
assign res_slot = res_index(reg_addr);
assign cur_chan = ctl_five_r[`ATP_BIT_MULT]
    ? ((ctl_five_r[`ATP_BIT_S8CM] ? 3'h0 : {ctl_five_r[2], 2'h0}) + conv_idx_r)
    : ctl_five_r[2:0];
assign res_word = {sar_r, {(16-RES_BITS){1'b0}}};

// ==========================================================
// pin view, never reset, no write path
// follow pins
always @(posedge clk_sys) begin
    pin_r <= analog_pin_digital_in;
end

// ==========================================================
// control and test registers
always @(posedge clk_sys) begin
    if (rst_any) begin
        ctl_two_r <= (reset_n && soft_rst_r)
            ? (`ATP_RST_BYTE | 8'h80) : `ATP_RST_BYTE;
        ctl_three_r <= `ATP_RST_BYTE;
        ctl_five_r <= `ATP_RST_BYTE;
        tst_sel_r <= 4'h0;
        tst_out_r <= 1'b0;
        soft_rst_r <= 1'b0;
    end else begin
        if (reg_wr && reg_addr == `ATP_OFS_CTL_TWO) begin
            ctl_two_r <= reg_wdata;
        end
        if (reg_wr && reg_addr == `ATP_OFS_CTL_THREE) begin
            ctl_three_r <= reg_wdata;
        end
        if (reg_wr && reg_addr == `ATP_OFS_CTL_FIVE) begin
            ctl_five_r <= reg_wdata;
        end
        // select and route bits
        // a soft reset write leaves the select bits alone, so no
        // short-lived test route shows before the reset lands
        if (wr_test_ok && reg_addr == `ATP_OFS_TEST_LOW) begin
            if (reg_wdata[`ATP_BIT_RST]) begin
                soft_rst_r <= 1'b1;
            end else begin
                tst_sel_r <= reg_wdata[3:0];
                tst_out_r <= reg_wdata[`ATP_BIT_TEST_MUX_OUTPUT];
            end
        end
    end
end

// ==========================================================
// sequencer: one approximation step per tick window
always @(posedge clk_sys) begin
    if (rst_any) begin
        sar_r <= `ATP_RST_SAR;
        busy_r <= 1'b0;
        conv_idx_r <= 3'h0;
        bit_idx_r <= 4'h0;
        tick_r <= 5'h00;
        seq_done_r <= 1'b0;
        chan_flags_r <= 8'h00;
    end else if (reg_wr && reg_addr == `ATP_OFS_CTL_FIVE) begin
        busy_r <= 1'b1;
        conv_idx_r <= 3'h0;
        bit_idx_r <= TOP_BIT;
        tick_r <= 5'h00;
        sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
        seq_done_r <= 1'b0;
        chan_flags_r <= 8'h00;
    end else if (stop_mode) begin
        busy_r <= 1'b0;
    end else begin
        if (wr_test_ok && reg_addr == `ATP_OFS_TEST_HIGH) begin
            sar_r[RES_BITS-1:2] <= reg_wdata;
        end else if (wr_test_ok && reg_addr == `ATP_OFS_TEST_LOW) begin
            sar_r[1:0] <= reg_wdata[7:6];
        end else if (busy_r && !halt_now) begin
            if (tick_r != `ATP_CONV_CYCLES) begin
                tick_r <= tick_r + 5'h01;
            end else begin
                tick_r <= 5'h00;
                if (!cmp_hi) begin
                    sar_r[bit_idx_r] <= 1'b0;
                end
                if (bit_idx_r != 4'h0) begin
                    bit_idx_r <= bit_idx_r - 4'h1;
                    sar_r[bit_idx_r - 4'h1] <= 1'b1;
                end else begin
                    // one conversion done, flag its slot
                    chan_flags_r[conv_idx_r] <= 1'b1;
                    bit_idx_r <= TOP_BIT;
                    sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
                    if (conv_idx_r == seq_len_m1) begin
                        seq_done_r <= 1'b1;
                        conv_idx_r <= 3'h0;
                        busy_r <= ctl_five_r[`ATP_BIT_SCAN];
                    end else begin
                        conv_idx_r <= conv_idx_r + 3'h1;
                    end
                end
            end
        end
    end
end

// ==========================================================
// result store; no reset, no bus write path
always @(posedge clk_sys) begin
    if (busy_r && !halt_now && !stop_mode && tick_r == `ATP_CONV_CYCLES
        && bit_idx_r == 4'h0) begin
        result_mem[conv_idx_r] <= {res_word[15:7], cmp_hi, res_word[5:0]};
    end
end

// ==========================================================
// read path and analog outputs
always @(posedge clk_sys) begin
    if (!reset_n) begin
        reg_rdata <= 8'h00;
        sample_chan <= 3'h0;
        dac_code <= {RES_BITS{1'b0}};
        factory_test_select <= 4'h0;
        test_mux_output <= 1'b0;
    end else begin
        sample_chan <= cur_chan;
        dac_code <= sar_r;
        factory_test_select <= tst_sel_r;
        test_mux_output <= tst_out_r;
        reg_rdata <= 8'h00;
        if (reg_rd) begin
            if (reg_addr == `ATP_OFS_TEST_HIGH) begin
                reg_rdata <= special_mode ? sar_r[RES_BITS-1:2] : 8'h00;
            end else if (reg_addr == `ATP_OFS_TEST_LOW) begin
                reg_rdata <= special_mode
                    ? {sar_r[1:0], 1'b0, tst_out_r, tst_sel_r} : 8'h00;
            end else if (reg_addr == `ATP_OFS_PIN_INPUT) begin
                reg_rdata <= pin_r;
            end else if (reg_addr == `ATP_OFS_CTL_TWO) begin
                reg_rdata <= ctl_two_r;
            end else if (reg_addr == `ATP_OFS_CTL_THREE) begin
                reg_rdata <= ctl_three_r;
            end else if (reg_addr == `ATP_OFS_CTL_FIVE) begin
                reg_rdata <= ctl_five_r;
            end else if (reg_addr == `ATP_OFS_STATUS_HIGH) begin
                reg_rdata <= {seq_done_r, 4'h0, conv_idx_r};
            end else if (reg_addr == `ATP_OFS_STATUS_LOW) begin
                reg_rdata <= chan_flags_r;
            end else if ((reg_addr & `ATP_OFS_RESULT_MASK) == `ATP_OFS_RESULT_BASE) begin
                reg_rdata <= reg_addr[0] ? result_mem[res_slot][7:0]
                    : result_mem[res_slot][15:8];
            end
        end
    end
end

endmodule // atp_core

// ### design/atp_regs.vh
/*
 * register offsets, field positions and reset values of the converter
 * test, port input and result register block.
 * assumes byte-wide register port, one byte per offset.
 */
`ifndef ATP_REGS_VH
`define ATP_REGS_VH

// ==========================================================
// offsets
`define ATP_OFS_TEST_HIGH 8'h68
`define ATP_OFS_TEST_LOW 8'h69
`define ATP_OFS_PIN_INPUT 8'h6F
`define ATP_OFS_CTL_TWO 8'h62
`define ATP_OFS_CTL_THREE 8'h63
`define ATP_OFS_CTL_FIVE 8'h65
`define ATP_OFS_STATUS_HIGH 8'h66
`define ATP_OFS_STATUS_LOW 8'h67
`define ATP_OFS_RESULT_BASE 8'h70
`define ATP_OFS_RESULT_MASK 8'hF0

// ==========================================================
// field positions
`define ATP_BIT_RST 5
`define ATP_BIT_TEST_MUX_OUTPUT 4
`define ATP_BIT_PWR_UP 7
`define ATP_BIT_HALT_WAIT 6
`define ATP_BIT_FREEZE 0
`define ATP_BIT_SCAN 5
`define ATP_BIT_MULT 4
`define ATP_BIT_S8CM 6

// ==========================================================
// reset values
`define ATP_RST_BYTE 8'h00
`define ATP_RST_SAR 10'h000

// ==========================================================
// timing
`define ATP_CONV_CYCLES 5'h13

`endif

// ### testbench/adc_test_result_port_logic_tb_top.sv
/* bench for atp_core and analog model: port tasks, row table, modes.
   assumes the checker binds itself to atp_core. */
`timescale 1ns/100ps
module adc_test_result_port_logic_tb_top;
    localparam STOP_REC = 16; // plain default recovery span
    reg clk_sys, reset_n, reg_wr, reg_rd, special_mode, stop_mode, wait_mode;
    reg debug_mode = 1'b0;
    reg [7:0] reg_addr, reg_wdata, analog_pin_digital_in, v;
    reg [9:0] level = 10'h2D7;
    wire [7:0] reg_rdata;
    wire [9:0] dac_code;
    wire [3:0] factory_test_select;
    wire [2:0] sample_chan;
    wire test_mux_output, cmp_hi;
    reg [32:0] rows [0:6];
    integer num_errors = 0, check_count = 0, i;
    atp_core atp_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .special_mode(special_mode), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .debug_mode(debug_mode), .analog_pin_digital_in(analog_pin_digital_in),
        .cmp_hi(cmp_hi), .sample_chan(sample_chan), .dac_code(dac_code),
        .factory_test_select(factory_test_select), .test_mux_output(test_mux_output));
    atp_analog_model atp_analog_model_i (.dac_code(dac_code), .cmp_hi(cmp_hi), .level(level));
    // ==========
    // compare, bus cycles, status polling
    task chk(input [9:0] seen, input [9:0] exp, input [63:0] what);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0s exp %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // bounded wait on the sequence flag
    task poll(input integer n);
        v = 8'h00;
        repeat (n) if (!v[7]) rd(8'h66);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // run needs about 7400 cycles
    initial begin
        #1000000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial begin
        {reset_n, reg_wr, reg_rd, special_mode, stop_mode, wait_mode} = 6'h00;
        {reg_addr, reg_wdata, analog_pin_digital_in} = 24'h000000;
        rows[0] = {9'h000, 8'h68, 8'hA5, 8'h00};
        rows[1] = {9'h000, 8'h69, 8'h1F, 8'h00};
        rows[2] = {9'h05A, 8'h6F, 8'hFF, 8'h5A};
        rows[3] = {9'h1C3, 8'h6F, 8'h00, 8'hC3};
        rows[4] = {9'h100, 8'h68, 8'hA5, 8'hA5};
        rows[5] = {9'h100, 8'h69, 8'hC0, 8'hC0};
        rows[6] = {9'h000, 8'h50, 8'h77, 8'h00};
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 chk(dac_code, 10'h000, "sar");
        for (i = 0; i < 7; i = i + 1) begin
            {special_mode, analog_pin_digital_in} <= rows[i][32:24];
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(v, rows[i][7:0], "row");
        end
        special_mode <= 1'b1;
        for (i = 0; i < 32; i = i + 1) begin
            wr(8'h69, {3'h0, i[4:0]});
            @(posedge clk_sys);
            #1 chk({test_mux_output, factory_test_select}, i[4:0], "tsel");
        end
        wr(8'h62, 8'h80);
        wr(8'h68, 8'h5A);
        wr(8'h69, 8'h3F);
        repeat (2) @(posedge clk_sys);
        #1 chk({dac_code, test_mux_output}, 11'h000, "srst");
        rd(8'h62);
        chk(v, 8'h80, "ctl2");
        special_mode <= 1'b0;
        wr(8'h65, 8'h00);
        poll(600);
        chk(v[7], 1'b1, "scf");
        rd(8'h70);
        chk(v, 8'hB5, "res_hi");
        rd(8'h71);
        chk(v, 8'h80, "res_lo");
        wr(8'h70, 8'h00);
        rd(8'h70);
        chk(v, 8'hB5, "res_ro");
        wr(8'h65, 8'h00);
        rd(8'h66);
        chk(v[7], 1'b0, "restart");
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        stop_mode <= 1'b0;
        poll(600);
        chk(v[7], 1'b0, "stop");
        repeat (STOP_REC) @(posedge clk_sys);
        wr(8'h62, 8'hC0);
        wait_mode <= 1'b1;
        wr(8'h65, 8'h00);
        poll(600);
        chk(v[7], 1'b0, "halt");
        wait_mode <= 1'b0;
        poll(600);
        chk(v[7], 1'b1, "resume");
        wr(8'h63, 8'h01);
        debug_mode <= 1'b1;
        wr(8'h65, 8'h00);
        poll(600);
        chk(v[7], 1'b0, "freeze");
        debug_mode <= 1'b0;
        poll(600);
        chk(v[7], 1'b1, "thaw");
        wr(8'h62, 8'h00);
        wr(8'h65, 8'h00);
        poll(600);
        chk(v[7], 1'b0, "pwr_dn");
        stop_test;
    end
endmodule // adc_test_result_port_logic_tb_top

// ### testbench/atp_analog_model.sv
/* analog side model: one input level against the trial code.
   assumes dac_code is the live approximation register. */
`timescale 1ns/100ps
module atp_analog_model (
    // converter side
    input wire [9:0] dac_code,
    output wire cmp_hi,
    // bench side
    input wire [9:0] level
);
    // ==========
    // strict compare, so a tie drops the trial bit
    assign cmp_hi = level > dac_code;
endmodule // atp_analog_model

// ### testbench/atp_core_sva.sv
/* port checker for atp_core: read timing, test bytes, pin view.
   assumes the byte register map; bound from this file. */
`timescale 1ns/100ps
module atp_core_sva #(parameter RES_BITS = 10) (
    // clock, reset and register port
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // modes, pins and converter outputs
    input wire special_mode,
    input wire [7:0] analog_pin_digital_in,
    input wire [RES_BITS-1:0] dac_code,
    input wire [3:0] factory_test_select,
    input wire test_mux_output
);
    // ==========
    // shorthands
    wire t_hi = reg_addr == 8'h68;
    wire lo_wr = reg_wr && special_mode && reg_addr == 8'h69;
    wire [7:0] sar_hi = dac_code[RES_BITS-1 -: 8];
    wire [4:0] tsel_w = reg_wdata[4:0];
    wire [4:0] tsel_o = {test_mux_output, factory_test_select};
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_lo_wr;
        lo_wr;
    endsequence
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_tst_nrm;
        reg_rd && !special_mode && (t_hi || reg_addr == 8'h69) |=> reg_rdata == 8'h00;
    endproperty
    a_tst_nrm: assert property (p_tst_nrm) else $error("test read");
    property p_tsel_hold;
        !lo_wr && !$past(lo_wr) && !$past(lo_wr, 2) |=> $stable(tsel_o);
    endproperty
    a_tsel_hold: assert property (p_tsel_hold) else $error("test sel moved");
    property p_tst_rd; reg_rd && special_mode && t_hi |=> reg_rdata == sar_hi; endproperty
    a_tst_rd: assert property (p_tst_rd) else $error("sar read");
    property p_sar_wr;
        reg_wr && special_mode && t_hi |=> ##1 sar_hi == $past(reg_wdata, 2);
    endproperty
    a_sar_wr: assert property (p_sar_wr) else $error("sar load");
    property p_srst;
        s_lo_wr ##0 reg_wdata[5] |=> ##2 dac_code == 0 && tsel_o == 5'h00;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset");
    property p_tsel;
        s_lo_wr ##0 !reg_wdata[5] |=> ##1 tsel_o == $past(tsel_w, 2);
    endproperty
    a_tsel: assert property (p_tsel) else $error("test select");
    property p_pin;
        reg_rd && reg_addr == 8'h6F |=> reg_rdata == $past(analog_pin_digital_in, 2);
    endproperty
    a_pin: assert property (p_pin) else $error("pin view");
endmodule // atp_core_sva
bind atp_core atp_core_sva #(.RES_BITS(RES_BITS)) atp_core_sva_i (.*);
